/* File: bench/cic_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cic_consts.vh"
module cic_chk
(
  // clock, reset, i/o bus
  input wire logic        clk_in, rstn_in, io_wr_in, io_rd_in, io_sel_out,
  input wire logic [7:0]  io_addr_in, io_rdata_out, vector_high_out,
  // sequencer events
  input wire logic        enable_op_in, disable_op_in, sample_in, ack_in, undef_fetch_in,
  input wire logic        load_acc_vector_op_in, load_acc_refresh_op_in,
  // core responses
  input wire logic        pv_out, pv_valid_out, irq_pending_out, vec_direct_out,
  input wire logic        dma_main_enable_clr_out, trap_bus_state_out, cycle_inhibit_out,
  input wire logic        primary_enable_flag_out, secondary_enable_flag_out,
  input wire logic [3:0]  irq_code_out,
  input wire logic [15:0] vec_addr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire logic hit = io_addr_in == `CIC_ADDR_VLOW || io_addr_in == `CIC_ADDR_TIC;
  wire logic lda = load_acc_vector_op_in || load_acc_refresh_op_in;
  // flag ops in the same cycle would legally change what the load sees
  wire logic quiet = !enable_op_in && !disable_op_in;
  sequence s_trap_req;
    sample_in && ack_in && undef_fetch_in;
  endsequence
  sequence s_trap_rsp;
    trap_bus_state_out && irq_code_out == `CIC_CODE_TRAP && vec_addr_out == `CIC_TRAP_ADDR
    ##1 cycle_inhibit_out;
  endsequence
  property p_sel; (io_wr_in || io_rd_in) && hit |=> io_sel_out; endproperty
  a_sel: assert property (p_sel) else $error("no select on mapped access");
  property p_unmap; io_rd_in && !hit |=> io_rdata_out == 8'h00 && !io_sel_out; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  property p_trap; s_trap_req |=> s_trap_rsp; endproperty
  a_trap: assert property (p_trap) else $error("bad trap response");
  property p_dis; disable_op_in |-> ##2 !primary_enable_flag_out; endproperty
  a_dis: assert property (p_dis) else $error("disable left flag set");
  property p_en; enable_op_in && !disable_op_in |-> ##2 primary_enable_flag_out; endproperty
  a_en: assert property (p_en) else $error("enable left flag clear");
  property p_nmi;
    dma_main_enable_clr_out |-> irq_code_out == `CIC_CODE_NMI
      && vec_addr_out == `CIC_NMI_ADDR && vec_direct_out;
  endproperty
  a_nmi: assert property (p_nmi) else $error("bad nmi vector");
  property p_nmi_fl;
    dma_main_enable_clr_out |=> !primary_enable_flag_out
      && secondary_enable_flag_out == $past(primary_enable_flag_out);
  endproperty
  a_nmi_fl: assert property (p_nmi_fl) else $error("nmi flag save wrong");
  property p_pv; lda && quiet |=> pv_valid_out && pv_out == secondary_enable_flag_out; endproperty
  a_pv: assert property (p_pv) else $error("parity copy wrong");
  property p_nosmp; sample_in && (lda || !quiet) |=> !irq_pending_out; endproperty
  a_nosmp: assert property (p_nosmp) else $error("sampled during flag op");
  property p_vhi;
    irq_pending_out && irq_code_out > `CIC_CODE_EXT0 && irq_code_out != `CIC_CODE_NONE
      |-> vec_addr_out[15:8] == vector_high_out && !vec_direct_out;
  endproperty
  a_vhi: assert property (p_vhi) else $error("table high byte wrong");
endmodule
`default_nettype wire

/* File: bench/cic_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cic_src_model
(
  // clock and bench requests
  input  wire logic       clk_in,
  input  wire logic       nmi_fire_in,
  input  wire logic [2:0] ext_lvl_in,
  // active-low request pins
  output var  logic       nmi_n_out,
  output var  logic [2:0] ext_n_out
);
  // pins move on the falling edge, clear of the core's sampling edge
  always @(negedge clk_in)
  begin
    nmi_n_out <= ~nmi_fire_in;
    ext_n_out <= ~ext_lvl_in;
  end
  initial
  begin
    nmi_n_out = 1'b1;
    ext_n_out = 3'h7;
  end
endmodule
`default_nettype wire

/* File: bench/cic_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cic_consts.vh"
module cpu_interrupt_control_tb;
  localparam WR = 12'h800, RD = 12'h400, EN = 12'h200, DIS = 12'h100, NRET = 12'h080;
  localparam LAV = 12'h040, LAR = 12'h020, LVH = 12'h010, SMP = 12'h008, ACK = 12'h004;
  localparam UF = 12'h002, U3 = 12'h001;
  logic             clk_in = 1'b0;
  logic             rstn_in = 1'b0;
  logic             maskable_return_op_in = 1'b0;
  logic             nf = 1'b0;
  logic [2:0]       xl = 3'h0;
  logic [11:0]      pl = 12'h000;
  logic [7:0]       io_addr_in = 8'h00;
  logic [7:0]       io_wdata_in = 8'h00;
  logic [7:0]       acc_in = 8'h00;
  logic [9:0]       int_req_in = 10'h000;
  logic [7:0]       vh = 8'h00;
  logic [7:0]       vl = 8'h00;
  wire logic        io_wr_in, io_rd_in, enable_op_in, disable_op_in, nonmaskable_return_op_in;
  wire logic        load_acc_vector_op_in, load_acc_refresh_op_in, load_vector_high_op_in;
  wire logic        sample_in, ack_in, undef_fetch_in, undef_third_in, nmi_n_in;
  wire logic        ext_request_line0_n_in, ext_request_line1_n_in, ext_request_line2_n_in;
  wire logic        io_sel_out, pv_out, pv_valid_out, irq_pending_out, vec_direct_out;
  wire logic        dma_main_enable_clr_out, trap_bus_state_out, cycle_inhibit_out;
  wire logic        primary_enable_flag_out, secondary_enable_flag_out;
  wire logic [2:0]  ext_n;
  wire logic [7:0]  io_rdata_out, vector_high_out;
  wire logic [3:0]  irq_code_out;
  wire logic [15:0] vec_addr_out;
  int               err_count = 0;
  int               checked = 0;
  int               cyc = 0;
  int               k;
  assign {io_wr_in, io_rd_in, enable_op_in, disable_op_in, nonmaskable_return_op_in,
          load_acc_vector_op_in, load_acc_refresh_op_in, load_vector_high_op_in,
          sample_in, ack_in, undef_fetch_in, undef_third_in} = pl;
  assign {ext_request_line2_n_in, ext_request_line1_n_in, ext_request_line0_n_in} = ext_n;
  cic_top #(.NINT(10)) DUT (.*);
  cic_src_model SRC (.clk_in(clk_in), .nmi_fire_in(nf), .ext_lvl_in(xl),
                     .nmi_n_out(nmi_n_in), .ext_n_out(ext_n));
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_count++;
      stop_test;
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one op per two cycles keeps every pulse exactly one clock wide
  task op(input logic [11:0] m, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    io_addr_in = a;
    io_wdata_in = d;
    acc_in = d;
    pl = m;
    @(negedge clk_in);
    pl = 12'h000;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    op(RD, a, 8'h00);
    chk(16'(io_rdata_out), 16'(e));
    chk(16'(io_sel_out), 16'(a == 8'h33 || a == 8'h34));
  endtask
  task fl(input logic [1:0] e);
    @(negedge clk_in);
    chk(16'({primary_enable_flag_out, secondary_enable_flag_out}), 16'(e));
  endtask
  task vc(input logic [3:0] c, input logic [15:0] v);
    chk(16'(irq_code_out), 16'(c));
    chk(vec_addr_out, v);
  endtask
  function automatic logic [3:0] ecode(input logic [9:0] r);
    ecode = 4'hF;
    for (int b = 9; b >= 0; b--)
      if (r[b])
        ecode = 4'(b + 5);
  endfunction
  initial
  begin
    k = $urandom(32'hcf93);
    repeat (5) @(negedge clk_in);
    rstn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk(16'(vector_high_out), 16'h0000);
    fl(2'b00);
    rc(8'h33, 8'h00);
    rc(8'h34, 8'h01);
    rc(8'h35, 8'h00);
    repeat (2)
    begin
      vl = 8'($urandom);
      op(WR, 8'h33, vl);
      rc(8'h33, vl & 8'hE0);
    end
    op(WR, 8'h34, 8'hF8);
    rc(8'h34, 8'h00);
    vh = 8'($urandom);
    op(LVH, 8'h00, vh);
    // the output copy trails the register by one clock
    @(negedge clk_in);
    chk(16'(vector_high_out), 16'(vh));
    xl = 3'b010;
    op(EN, 8'h00, 8'h00);
    repeat (5) @(negedge clk_in);
    op(SMP, 8'h00, 8'h00);
    chk(16'(irq_pending_out), 16'h0000);
    op(WR, 8'h34, 8'h07);
    op(SMP, 8'h00, 8'h00);
    vc(4'h3, {vh, vl[7:5], 5'h00});
    xl = 3'b101;
    repeat (5) @(negedge clk_in);
    op(SMP, 8'h00, 8'h00);
    chk(16'(irq_code_out), 16'h0002);
    chk(16'(vec_direct_out), 16'h0001);
    xl = 3'b100;
    repeat (5) @(negedge clk_in);
    op(SMP, 8'h00, 8'h00);
    vc(4'h4, {vh, vl[7:5], 5'h02});
    xl = 3'b000;
    repeat (5) @(negedge clk_in);
    for (int n = 0; n < 8; n++)
    begin
      int_req_in = n == 0 ? 10'h200 : n == 1 ? 10'h300 : 10'($urandom) | 10'h200;
      op(SMP, 8'h00, 8'h00);
      vc(ecode(int_req_in), {vh, vl[7:5], ecode(int_req_in) - 4'h3, 1'b0});
    end
    // an accepted maskable request clears both flags
    op(SMP | ACK, 8'h00, 8'h00);
    fl(2'b00);
    op(EN, 8'h00, 8'h00);
    op(DIS, 8'h00, 8'h00);
    op(SMP, 8'h00, 8'h00);
    chk(16'(irq_pending_out), 16'h0000);
    op(EN | SMP, 8'h00, 8'h00);
    chk(16'(irq_pending_out), 16'h0000);
    int_req_in = 10'h000;
    fl(2'b11);
    nf = 1'b1;
    repeat (2) @(negedge clk_in);
    nf = 1'b0;
    repeat (5) @(negedge clk_in);
    op(SMP | ACK, 8'h00, 8'h00);
    vc(4'h1, 16'h0066);
    chk(16'(dma_main_enable_clr_out), 16'h0001);
    fl(2'b01);
    op(LAV, 8'h00, 8'h00);
    chk(16'({pv_valid_out, pv_out}), 16'h0003);
    fl(2'b01);
    op(NRET, 8'h00, 8'h00);
    fl(2'b11);
    maskable_return_op_in = 1'b1;
    @(negedge clk_in);
    maskable_return_op_in = 1'b0;
    fl(2'b11);
    op(LAR, 8'h00, 8'h00);
    chk(16'({pv_valid_out, pv_out}), 16'h0003);
    op(DIS, 8'h00, 8'h00);
    op(SMP | ACK | UF | U3, 8'h00, 8'h00);
    vc(4'h0, 16'h0000);
    chk(16'(trap_bus_state_out), 16'h0001);
    @(negedge clk_in);
    chk(16'(cycle_inhibit_out), 16'h0001);
    rc(8'h34, 8'hC7);
    op(WR, 8'h34, 8'h07);
    rc(8'h34, 8'h47);
    op(UF, 8'h00, 8'h00);
    rc(8'h34, 8'h87);
    rstn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk(16'(vector_high_out), 16'h0000);
    fl(2'b00);
    rc(8'h34, 8'h01);
    stop_test;
  end
endmodule
bind cic_top cic_chk u_chk (.*);
`default_nettype wire

/* File: design/cic_consts.vh */
`ifndef CIC_CONSTS_VH
`define CIC_CONSTS_VH
// i/o addresses
`define CIC_ADDR_VLOW      8'h33
`define CIC_ADDR_TIC       8'h34
// reset values
`define CIC_VLOW_RST       3'h0
`define CIC_VHIGH_RST      8'h00
`define CIC_EXT_EN_RST     3'h1
`define CIC_SYNC_IDLE      3'h7
`define CIC_LVL_IDLE       1'b1
// trap_int_control fields
`define CIC_TIC_TRAP       7
`define CIC_TIC_FOBJ       6
`define CIC_TIC_EN2        2
`define CIC_TIC_EN1        1
`define CIC_TIC_EN0        0
// vector_low_base field: upper three bits
`define CIC_VLOW_HI        7
`define CIC_VLOW_LO        5
// restart addresses
`define CIC_TRAP_ADDR      16'h0000
`define CIC_NMI_ADDR       16'h0066
// source count and indices in priority order
`define CIC_NSRC           15
`define CIC_SRC_TRAP       0
`define CIC_SRC_NMI        1
`define CIC_SRC_EXT0       2
`define CIC_SRC_EXT1       3
`define CIC_SRC_EXT2       4
`define CIC_SRC_INT_LO     5
`define CIC_NINT           10
// source codes
`define CIC_CODE_NONE      4'hF
`define CIC_CODE_TRAP      4'h0
`define CIC_CODE_NMI       4'h1
`define CIC_CODE_EXT0      4'h2
`define CIC_CODE_EXT1      4'h3
`define CIC_CODE_LAST      4'hE
`endif

/* File: design/cic_prio_enc.v */
`timescale 1ns/1ps
`default_nettype none
`include "cic_consts.vh"
module cic_prio_enc
#(
  parameter N = 15
)
(
  // requests, bit 0 highest
  input  wire [N-1:0] req_in,
  // winner
  output reg          any_out,
  output reg  [3:0]   code_out
);
  integer src;
  always @*
  begin
    any_out  = 1'b0;
    code_out = `CIC_CODE_NONE;
    // scan from lowest so the highest wins last
    for (src = N - 1; src >= 0; src = src - 1)
    begin
      if (req_in[src])
      begin
        any_out  = 1'b1;
        code_out = src[3:0];
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/cic_top.v */
// Behaviour
// - fifteen sources, fixed priority: trap, nmi, external levels, timers, dma, serial
// - lowest sources: dma channel 1, clocked serial, async serial 0, async serial 1
// - vector-high register forms upper byte of every vectored table address
// - vector-high clears on reset; written only by dedicated transfer instruction
// - low address byte: three vector-low bits plus five fixed per-source bits
// - vector-low register at i/o 0x33, reset to zero
// - control at 0x34 holds external enables bits 2-0; reset 001
// - trap flag bit 7 set by undefined fetch; write 0 clears, 1 ignored
// - read-only fetch-object bit 6 selects stacked counter minus one or two
// - primary flag zero blocks all maskable; disable clears, enable sets it
// - nmi copies primary to secondary then clears primary; nmi return restores
// - load-acc vector/refresh copies secondary flag to parity bit, flags unchanged
// - no requests sampled during enable, disable or load-acc special instructions
// - reset clears both enable flags
// - undefined opcode fetch traps regardless of primary flag, including mode-0 ack
// - trap sets flag, pushes pc, resumes at logical address zero
// - no bus release, refresh, dma or wait cycles right after trap state
// - lines 1 and 2 masked by primary flag and by own enable bits
// - nmi clears dma main enable, pushes pc, resumes at 0x0066
`timescale 1ns/1ps
`default_nettype none
`include "cic_consts.vh"
module cic_top
#(
  parameter NINT = 10
)
(
  // clock and reset
  input  wire            clk_in,
  input  wire            rstn_in,
  // internal i/o bus
  input  wire [7:0]      io_addr_in,
  input  wire [7:0]      io_wdata_in,
  input  wire            io_wr_in,
  input  wire            io_rd_in,
  output reg  [7:0]      io_rdata_out,
  output reg             io_sel_out,
  // sequencer instruction events, one-cycle pulses
  input  wire            enable_op_in,
  input  wire            disable_op_in,
  input  wire            nonmaskable_return_op_in,
  input  wire            maskable_return_op_in,
  input  wire            load_acc_vector_op_in,
  input  wire            load_acc_refresh_op_in,
  input  wire            load_vector_high_op_in,
  input  wire [7:0]      acc_in,
  input  wire            sample_in,
  input  wire            ack_in,
  input  wire            undef_fetch_in,
  input  wire            undef_third_in,
  // request sources
  input  wire            nmi_n_in,
  input  wire            ext_request_line0_n_in,
  input  wire            ext_request_line1_n_in,
  input  wire            ext_request_line2_n_in,
  input  wire [NINT-1:0] int_req_in,
  // to sequencer
  output reg  [7:0]      vector_high_out,
  output reg             pv_out,
  output reg             pv_valid_out,
  output reg             irq_pending_out,
  output reg  [3:0]      irq_code_out,
  output reg  [15:0]     vec_addr_out,
  output reg             vec_direct_out,
  output reg             dma_main_enable_clr_out,
  output reg             trap_bus_state_out,
  output reg             cycle_inhibit_out,
  output reg             primary_enable_flag_out,
  output reg             secondary_enable_flag_out
);
  reg  [7:0] vector_high_r;
  reg  [2:0] vector_low_base_r;
  reg        trap_flag_r;
  reg        fetch_object_flag_r;
  reg  [2:0] ext_en_r;
  reg        primary_enable_flag_r;
  reg        secondary_enable_flag_r;
  reg        nmi_edge_r;
  reg  [2:0] nmi_sync_r;
  reg  [2:0] l0_sync_r;
  reg  [2:0] l1_sync_r;
  reg  [2:0] l2_sync_r;
  reg        nmi_lvl_r;
  reg        l0_lvl_r;
  reg        l1_lvl_r;
  reg        l2_lvl_r;
  wire [`CIC_NSRC-1:0] req_w;
  wire                 any_w;
  wire [3:0]           code_w;
  wire [4:0]           low5_w;
  wire                 spec_op_w;
  wire                 take_w;
  wire                 mask_ok_w;
  reg  [7:0] vlow_rd;
  reg  [7:0] tic_rd;

  // pin synchronisers: a change counts once stages 2 and 3 agree
  // reset to the idle high level so a release never shows a false edge
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      nmi_sync_r <= `CIC_SYNC_IDLE;
      l0_sync_r  <= `CIC_SYNC_IDLE;
      l1_sync_r  <= `CIC_SYNC_IDLE;
      l2_sync_r  <= `CIC_SYNC_IDLE;
      nmi_lvl_r  <= `CIC_LVL_IDLE;
      l0_lvl_r   <= `CIC_LVL_IDLE;
      l1_lvl_r   <= `CIC_LVL_IDLE;
      l2_lvl_r   <= `CIC_LVL_IDLE;
    end
    else
    begin
      nmi_sync_r <= {nmi_sync_r[1:0], nmi_n_in};
      l0_sync_r  <= {l0_sync_r[1:0], ext_request_line0_n_in};
      l1_sync_r  <= {l1_sync_r[1:0], ext_request_line1_n_in};
      l2_sync_r  <= {l2_sync_r[1:0], ext_request_line2_n_in};
      if (nmi_sync_r[2] == nmi_sync_r[1])
        nmi_lvl_r <= nmi_sync_r[2];
      if (l0_sync_r[2] == l0_sync_r[1])
        l0_lvl_r <= l0_sync_r[2];
      if (l1_sync_r[2] == l1_sync_r[1])
        l1_lvl_r <= l1_sync_r[2];
      if (l2_sync_r[2] == l2_sync_r[1])
        l2_lvl_r <= l2_sync_r[2];
    end
  end

  wire nmi_fall_w = nmi_lvl_r && (nmi_sync_r[2] == nmi_sync_r[1]) && !nmi_sync_r[2];
  wire nmi_taken_w;

  // nmi is edge latched and held until serviced; a new edge beats the clear
  always @(posedge clk_in)
  begin
    if (!rstn_in)
      nmi_edge_r <= 1'b0;
    else if (nmi_fall_w)
      nmi_edge_r <= 1'b1;
    else if (nmi_taken_w)
      nmi_edge_r <= 1'b0;
  end

  assign spec_op_w = enable_op_in | disable_op_in |
                     load_acc_vector_op_in | load_acc_refresh_op_in;
  assign take_w    = sample_in & ~spec_op_w;
  assign mask_ok_w = primary_enable_flag_r;

  // request vector in priority order, bit 0 highest
  assign req_w[`CIC_SRC_TRAP] = undef_fetch_in;
  assign req_w[`CIC_SRC_NMI]  = nmi_edge_r;
  assign req_w[`CIC_SRC_EXT0] = ~l0_lvl_r & ext_en_r[`CIC_TIC_EN0] & mask_ok_w;
  assign req_w[`CIC_SRC_EXT1] = ~l1_lvl_r & ext_en_r[`CIC_TIC_EN1] & mask_ok_w;
  assign req_w[`CIC_SRC_EXT2] = ~l2_lvl_r & ext_en_r[`CIC_TIC_EN2] & mask_ok_w;
  // internal sources: bit NINT-1 is async serial 1, the lowest
  assign req_w[`CIC_NSRC-1:`CIC_SRC_INT_LO] = int_req_in & {NINT{mask_ok_w}};

  cic_prio_enc #(.N(`CIC_NSRC)) u_prio
  (
    .req_in   (req_w),
    .any_out  (any_w),
    .code_out (code_w)
  );

  cic_vec_rom u_rom
  (
    .code_in  (code_w),
    .low5_out (low5_w)
  );

  wire trap_now_w = take_w && any_w && code_w == `CIC_CODE_TRAP;
  wire nmi_now_w  = take_w && any_w && code_w == `CIC_CODE_NMI;
  // trap detected on the fetch itself, never blocked by special ops
  wire trap_evt_w = undef_fetch_in;
  assign nmi_taken_w = nmi_now_w & ack_in;
  wire mask_ack_w = take_w && any_w && ack_in && code_w > `CIC_CODE_NMI;

  // enable flags
  // one update per cycle: nmi accept, then ack or disable, enable, nmi return
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      primary_enable_flag_r   <= 1'b0;
      secondary_enable_flag_r <= 1'b0;
    end
    else if (nmi_taken_w)
    begin
      secondary_enable_flag_r <= primary_enable_flag_r;
      primary_enable_flag_r   <= 1'b0;
    end
    else if (mask_ack_w || disable_op_in)
    begin
      primary_enable_flag_r   <= 1'b0;
      secondary_enable_flag_r <= 1'b0;
    end
    else if (enable_op_in)
    begin
      primary_enable_flag_r   <= 1'b1;
      secondary_enable_flag_r <= 1'b1;
    end
    else if (nonmaskable_return_op_in)
      primary_enable_flag_r <= secondary_enable_flag_r;
  end

  // only the two mapped addresses respond; others are left to the outside bus
  wire wr_vlow_w = io_wr_in && io_addr_in == `CIC_ADDR_VLOW;
  wire wr_tic_w  = io_wr_in && io_addr_in == `CIC_ADDR_TIC;

  // registers
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      vector_high_r       <= `CIC_VHIGH_RST;
      vector_low_base_r   <= `CIC_VLOW_RST;
      ext_en_r            <= `CIC_EXT_EN_RST;
      trap_flag_r         <= 1'b0;
      fetch_object_flag_r <= 1'b0;
    end
    else
    begin
      if (load_vector_high_op_in)
        vector_high_r <= acc_in;
      if (wr_vlow_w)
        vector_low_base_r <= io_wdata_in[`CIC_VLOW_HI:`CIC_VLOW_LO];
      if (wr_tic_w)
        ext_en_r <= io_wdata_in[`CIC_TIC_EN2:`CIC_TIC_EN0];
      // set beats a software clear in the same cycle
      if (trap_evt_w)
      begin
        trap_flag_r         <= 1'b1;
        fetch_object_flag_r <= undef_third_in;
      end
      else if (wr_tic_w && !io_wdata_in[`CIC_TIC_TRAP])
        trap_flag_r <= 1'b0;
    end
  end

  // read words built from field positions; unused bits read 0
  always @*
  begin
    vlow_rd = 8'h00;
    vlow_rd[`CIC_VLOW_HI:`CIC_VLOW_LO] = vector_low_base_r;
    tic_rd = 8'h00;
    tic_rd[`CIC_TIC_TRAP] = trap_flag_r;
    tic_rd[`CIC_TIC_FOBJ] = fetch_object_flag_r;
    tic_rd[`CIC_TIC_EN2:`CIC_TIC_EN0] = ext_en_r;
  end

  // outputs, all registered
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      io_rdata_out              <= 8'h00;
      io_sel_out                <= 1'b0;
      vector_high_out           <= `CIC_VHIGH_RST;
      pv_out                    <= 1'b0;
      pv_valid_out              <= 1'b0;
      irq_pending_out           <= 1'b0;
      irq_code_out              <= `CIC_CODE_NONE;
      vec_addr_out              <= 16'h0000;
      vec_direct_out            <= 1'b0;
      dma_main_enable_clr_out   <= 1'b0;
      trap_bus_state_out        <= 1'b0;
      cycle_inhibit_out         <= 1'b0;
      primary_enable_flag_out   <= 1'b0;
      secondary_enable_flag_out <= 1'b0;
    end
    else
    begin
      io_sel_out   <= (io_rd_in | io_wr_in) &&
                      (io_addr_in == `CIC_ADDR_VLOW || io_addr_in == `CIC_ADDR_TIC);
      io_rdata_out <= 8'h00;
      if (io_rd_in && io_addr_in == `CIC_ADDR_VLOW)
        io_rdata_out <= vlow_rd;
      else if (io_rd_in && io_addr_in == `CIC_ADDR_TIC)
        io_rdata_out <= tic_rd;
      vector_high_out <= vector_high_r;
      pv_valid_out    <= load_acc_vector_op_in | load_acc_refresh_op_in;
      if (load_acc_vector_op_in || load_acc_refresh_op_in)
        pv_out <= secondary_enable_flag_r;
      irq_pending_out <= take_w & any_w;
      irq_code_out    <= (take_w & any_w) ? code_w : `CIC_CODE_NONE;
      vec_direct_out  <= trap_now_w | nmi_now_w | (take_w && code_w == `CIC_CODE_EXT0);
      if (trap_now_w)
        vec_addr_out <= `CIC_TRAP_ADDR;
      else if (nmi_now_w)
        vec_addr_out <= `CIC_NMI_ADDR;
      else
        vec_addr_out <= {vector_high_r, vector_low_base_r, low5_w};
      dma_main_enable_clr_out <= nmi_taken_w;
      trap_bus_state_out      <= trap_now_w & ack_in;
      // one cycle guard after the trap state
      cycle_inhibit_out <= trap_bus_state_out;
      primary_enable_flag_out   <= primary_enable_flag_r;
      secondary_enable_flag_out <= secondary_enable_flag_r;
    end
  end
endmodule
`default_nettype wire

/* File: design/cic_vec_rom.v */
`timescale 1ns/1ps
`default_nettype none
`include "cic_consts.vh"
module cic_vec_rom
(
  // source code from the arbiter
  input  wire [3:0] code_in,
  // fixed low five bits of the table address
  output reg  [4:0] low5_out
);
  // codes 3 to 14 map to 0x00,0x02,... in priority order
  wire [3:0] rel_w = code_in - `CIC_CODE_EXT1;
  always @*
  begin
    low5_out = 5'h00;
    if (code_in >= `CIC_CODE_EXT1 && code_in <= `CIC_CODE_LAST)
      low5_out = {rel_w, 1'b0};
  end
endmodule
`default_nettype wire
